// [core/tx_fail_pkg.sv]
// Shared constants and types for the transmit mode-change sequencer
package tx_fail_pkg;

   // ==========================================================================
   // Failure codes
   localparam logic [2:0] FAIL_PARALLEL_WIDTH = 3'h1;
   localparam logic [2:0] FAIL_INTERNAL_WIDTH = 3'h2;
   localparam logic [2:0] FAIL_CLOCK_DIVIDER  = 3'h3;
   localparam logic [2:0] FAIL_RESET_DONE     = 3'h4;

   // ==========================================================================
   // Register map (byte addresses) and fields
   localparam logic [7:0] REG_CONTROL = 8'h00;
   localparam logic [7:0] REG_VALUES  = 8'h04;
   localparam logic [7:0] REG_STATUS  = 8'h08;

   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_EN_LSB    = 1;
   localparam int NUM_ATTRS      = 3;

   localparam int VAL_PAR_LSB = 0;
   localparam int VAL_PAR_W   = 4;
   localparam int VAL_INT_LSB = 4;
   localparam int VAL_INT_W   = 2;
   localparam int VAL_DIV_LSB = 6;
   localparam int VAL_DIV_W   = 3;
   localparam int VAL_W       = 9;

   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_FAIL_BIT = 2;
   localparam int STAT_CODE_LSB = 4;
   localparam int STAT_RTRY_LSB = 8;

   localparam logic [2:0]      EN_RESET     = 3'h0;
   localparam logic [VAL_W-1:0] VALUES_RESET = 9'h000;

   // ==========================================================================
   // Reconfiguration port addresses of the transmit attributes
   localparam logic [8:0] ADDR_PARALLEL_WIDTH = 9'h07A;
   localparam logic [8:0] ADDR_INTERNAL_WIDTH = 9'h085;
   localparam logic [8:0] ADDR_CLOCK_DIVIDER  = 9'h07C;

   // ==========================================================================
   // Timing
   localparam int CLOCK_HZ           = 20_000_000;
   localparam int RESET_DONE_WAIT_US = 100;
   localparam int RESET_DONE_CYCLES  = RESET_DONE_WAIT_US * (CLOCK_HZ / 1_000_000);
   localparam int RCFG_WAIT_US       = 5;
   localparam int RCFG_WAIT_CYCLES   = RCFG_WAIT_US * (CLOCK_HZ / 1_000_000);

   // ==========================================================================
   // Types
   typedef struct packed
   {
      logic        en;
      logic        we;
      logic [8:0]  addr;
      logic [15:0] wdata;
   } rcfg_req_t;

   typedef struct packed
   {
      logic        rdy;
      logic [15:0] rdata;
   } rcfg_rsp_t;

   typedef enum logic [2:0] {SEQ_IDLE, SEQ_PICK, SEQ_ATTR_WAIT, SEQ_RST, SEQ_RST_WAIT} seq_state_t;
   typedef enum logic [2:0] {AP_IDLE, AP_WRITE, AP_WAIT_W, AP_READ, AP_WAIT_R} ap_state_t;

endpackage

// [core/tx_attr_port.sv]
// Write-then-read-back transactor on the transceiver reconfiguration port
`timescale 1ns/1ns
`default_nettype none
module tx_attr_port
   import tx_fail_pkg::*;
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RESET_N_IN,
   input  wire logic                   START_IN,
   input  wire logic [8:0]             ADDR_IN,
   input  wire logic [15:0]            DATA_IN,
   input  wire tx_fail_pkg::rcfg_rsp_t RSP_IN,
   output var  tx_fail_pkg::rcfg_req_t REQ_OUT,
   output logic                        DONE_OUT,
   output logic                        MATCH_OUT
);
   import tx_fail_pkg::*;

   typedef struct packed
   {
      ap_state_t   st;
      rcfg_req_t   req;
      logic [15:0] cnt;
      logic        done;
      logic        match;
   } ap_regs_t;

   ap_regs_t s;
   ap_regs_t next_s;

   // ==========================================================================
   // Sequencing
   always_comb
   begin
      next_s        = s;
      next_s.req.en = 1'b0;
      next_s.done   = 1'b0;
      case (s.st)
         AP_IDLE:
         begin
            if (START_IN)
            begin
               next_s.req.addr  = ADDR_IN;
               next_s.req.wdata = DATA_IN;
               next_s.st        = AP_WRITE;
            end
         end
         AP_WRITE:
         begin
            next_s.req.en = 1'b1;
            next_s.req.we = 1'b1;
            next_s.cnt    = 16'h0000;
            next_s.st     = AP_WAIT_W;
         end
         AP_WAIT_R, AP_WAIT_W:
         begin
            next_s.cnt = s.cnt + 16'h0001;
            if (RSP_IN.rdy)
            begin
               if (s.st == AP_WAIT_W)
                  next_s.st = AP_READ;
               else
               begin
                  // Read-back compared against the value written
                  next_s.match = (RSP_IN.rdata == s.req.wdata);
                  next_s.done  = 1'b1;
                  next_s.st    = AP_IDLE;
               end
            end
            // A silent port counts as a mismatch so the caller retries
            else if (s.cnt == 16'(RCFG_WAIT_CYCLES - 1))
            begin
               next_s.match = 1'b0;
               next_s.done  = 1'b1;
               next_s.st    = AP_IDLE;
            end
         end
         AP_READ:
         begin
            next_s.req.en = 1'b1;
            next_s.req.we = 1'b0;
            next_s.cnt    = 16'h0000;
            next_s.st     = AP_WAIT_R;
         end
         default:
            next_s.st = AP_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
         s <= '0;
      else
         s <= next_s;
   end

   assign REQ_OUT   = s.req;
   assign DONE_OUT  = s.done;
   assign MATCH_OUT = s.match;

endmodule
`default_nettype wire

// [core/tx_mode_change_failure_report.sv]
// Transmit mode-change sequencer with failure flag, cause code and Wishbone registers
//
// Summary of operation
// - Parallel width attribute still mismatching after all retries ends with code 1.
// - Internal width attribute still mismatching after all retries ends with code 2.
// - Serial clock divider attribute mismatching after all retries ends with code 3.
// - After writes, request datapath reset; no completion after retries gives code 4.
// - Every acknowledged attribute write is read back and compared; mismatch triggers a retry.
// - On failure drive the failure flag high and present the cause code.
// - Fail only after 2**top_bit - 1 retries; counter width set by parameter.
`timescale 1ns/1ns
`default_nettype none
module tx_mode_change_failure_report
   import tx_fail_pkg::*;
#(
   parameter int TX_RETRY_COUNTER_TOP_BIT = 3,
   parameter int RESET_DONE_WAIT          = RESET_DONE_CYCLES
)
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RESET_N_IN,
   input  wire logic                   WB_CYC_IN,
   input  wire logic                   WB_STB_IN,
   input  wire logic                   WB_WE_IN,
   input  wire logic [7:0]             WB_ADR_IN,
   input  wire logic [3:0]             WB_SEL_IN,
   input  wire logic [31:0]            WB_DAT_IN,
   output logic [31:0]                 WB_DAT_OUT,
   output logic                        WB_ACK_OUT,
   output var  tx_fail_pkg::rcfg_req_t RCFG_REQ_OUT,
   input  wire tx_fail_pkg::rcfg_rsp_t RCFG_RSP_IN,
   output logic                        TX_DATAPATH_RESET_OUT,
   input  wire logic                   TX_RESET_DONE_IN,
   output logic                        TX_FAIL_OUT,
   output logic [2:0]                  TX_FAIL_CODE_OUT,
   output logic                        TX_BUSY_OUT
);
   import tx_fail_pkg::*;

   // ==========================================================================
   // State, kept as one registered struct
   localparam int RW = TX_RETRY_COUNTER_TOP_BIT;
   localparam logic [RW-1:0] RETRY_MAX = '1;

   typedef struct packed
   {
      seq_state_t           st;
      logic [1:0]           step;
      logic [RW-1:0]        retry;
      logic [15:0]          wait_cnt;
      logic                 busy;
      logic                 done;
      logic                 fail;
      logic [2:0]           code;
      logic                 rst_req;
      logic                 done_prev;
      logic                 attr_start;
      logic [NUM_ATTRS-1:0] enables;
      logic [VAL_W-1:0]     values;
      logic                 ack;
      logic [31:0]          rdata;
   } regs_t;

   regs_t s;
   regs_t next_s;

   logic        attr_done;
   logic        attr_match;
   logic [8:0]  attr_addr;
   logic [15:0] attr_data;

   // ==========================================================================
   // Helpers
   function automatic logic [2:0] code_of(input logic [1:0] step);
      case (step)
         2'h0:    code_of = FAIL_PARALLEL_WIDTH;
         2'h1:    code_of = FAIL_INTERNAL_WIDTH;
         2'h2:    code_of = FAIL_CLOCK_DIVIDER;
         default: code_of = FAIL_RESET_DONE;
      endcase
   endfunction

   // Byte-lane merge for the values register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw, input logic en);
      merge8 = en ? nw : old;
   endfunction

   always_comb
   begin
      case (s.step)
         2'h0:
         begin
            attr_addr = ADDR_PARALLEL_WIDTH;
            attr_data = 16'(s.values[VAL_PAR_LSB +: VAL_PAR_W]);
         end
         2'h1:
         begin
            attr_addr = ADDR_INTERNAL_WIDTH;
            attr_data = 16'(s.values[VAL_INT_LSB +: VAL_INT_W]);
         end
         default:
         begin
            attr_addr = ADDR_CLOCK_DIVIDER;
            attr_data = 16'(s.values[VAL_DIV_LSB +: VAL_DIV_W]);
         end
      endcase
   end

   // ==========================================================================
   // Register bus and sequencer
   always_comb
   begin
      logic        hit;
      logic        start;
      logic [15:0] val16;
      hit   = WB_CYC_IN & WB_STB_IN;
      start = 1'b0;
      val16 = 16'(s.values);

      next_s            = s;
      next_s.attr_start = 1'b0;
      next_s.rst_req    = 1'b0;
      next_s.done_prev  = TX_RESET_DONE_IN;

      // Registered ack drops the cycle after it is seen
      next_s.ack = hit & ~s.ack;
      // Read data is latched with the ack so both stand for the same cycle
      if (hit & ~s.ack)
      begin
         next_s.rdata = 32'h0000_0000;
         case (WB_ADR_IN)
            REG_CONTROL: next_s.rdata[CTRL_EN_LSB +: NUM_ATTRS] = s.enables;
            REG_VALUES:  next_s.rdata[VAL_W-1:0] = s.values;
            REG_STATUS:
            begin
               next_s.rdata[STAT_BUSY_BIT]           = s.busy;
               next_s.rdata[STAT_DONE_BIT]           = s.done;
               next_s.rdata[STAT_FAIL_BIT]           = s.fail;
               next_s.rdata[STAT_CODE_LSB +: 3]      = s.code;
               next_s.rdata[STAT_RTRY_LSB +: RW]     = s.retry;
            end
            default:     next_s.rdata = 32'h0000_0000;
         endcase
      end
      if (hit & s.ack & WB_WE_IN)
      begin
         case (WB_ADR_IN)
            REG_CONTROL:
            begin
               // Enables may change at any time; start only acts when idle
               if (WB_SEL_IN[0])
               begin
                  next_s.enables = WB_DAT_IN[CTRL_EN_LSB +: NUM_ATTRS];
                  start          = WB_DAT_IN[CTRL_START_BIT];
               end
            end
            REG_VALUES:
            begin
               // Values are frozen while a sequence runs
               if (!s.busy)
               begin
                  val16[7:0]    = merge8(val16[7:0], WB_DAT_IN[7:0], WB_SEL_IN[0]);
                  val16[15:8]   = merge8(val16[15:8], WB_DAT_IN[15:8], WB_SEL_IN[1]);
                  next_s.values = val16[VAL_W-1:0];
               end
            end
            default:
               next_s.values = s.values;
         endcase
      end

      case (s.st)
         SEQ_IDLE:
         begin
            if (start)
            begin
               next_s.busy  = 1'b1;
               next_s.done  = 1'b0;
               next_s.fail  = 1'b0;
               // Code is kept; the fail flag says whether it is fresh
               next_s.step  = 2'h0;
               next_s.retry = '0;
               next_s.st    = SEQ_PICK;
            end
         end
         SEQ_PICK:
         begin
            if (s.step == 2'(NUM_ATTRS))
               next_s.st = SEQ_RST;
            else if (next_s.enables[s.step])
            begin
               next_s.attr_start = 1'b1;
               next_s.st         = SEQ_ATTR_WAIT;
            end
            // Disabled attributes are skipped without touching the port
            else
               next_s.step = s.step + 2'h1;
         end
         SEQ_ATTR_WAIT:
         begin
            if (attr_done)
            begin
               if (attr_match)
               begin
                  next_s.step  = s.step + 2'h1;
                  // Counter is shared with the reset step, so clear it per attribute
                  next_s.retry = '0;
                  next_s.st    = SEQ_PICK;
               end
               else if (s.retry == RETRY_MAX)
               begin
                  next_s.fail = 1'b1;
                  next_s.code = code_of(s.step);
                  next_s.busy = 1'b0;
                  next_s.st   = SEQ_IDLE;
               end
               else
               begin
                  next_s.retry = s.retry + 1'b1;
                  next_s.st    = SEQ_PICK;
               end
            end
         end
         SEQ_RST:
         begin
            // One-cycle pulse; the helper restarts its own sequence on it
            next_s.rst_req  = 1'b1;
            next_s.wait_cnt = 16'h0000;
            next_s.st       = SEQ_RST_WAIT;
         end
         SEQ_RST_WAIT:
         begin
            next_s.wait_cnt = s.wait_cnt + 16'h0001;
            // Only a fresh rising edge counts; a stale done level is ignored
            if (TX_RESET_DONE_IN & ~s.done_prev)
            begin
               next_s.done = 1'b1;
               next_s.busy = 1'b0;
               next_s.st   = SEQ_IDLE;
            end
            else if (s.wait_cnt == 16'(RESET_DONE_WAIT - 1))
            begin
               if (s.retry == RETRY_MAX)
               begin
                  next_s.fail = 1'b1;
                  next_s.code = FAIL_RESET_DONE;
                  next_s.busy = 1'b0;
                  next_s.st   = SEQ_IDLE;
               end
               else
               begin
                  // Each retry reissues the reset pulse
                  next_s.retry = s.retry + 1'b1;
                  next_s.st    = SEQ_RST;
               end
            end
         end
         default:
            next_s.st = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         s         <= '0;
         // Code never rests on a reserved value
         s.code    <= FAIL_PARALLEL_WIDTH;
         s.enables <= EN_RESET;
         s.values  <= VALUES_RESET;
      end
      else
         s <= next_s;
   end

   // ==========================================================================
   // Reconfiguration port transactor
   // A silent port ends as a mismatch inside it, never as a hang
   tx_attr_port u_attr_port
   (
      .CLOCK_IN   (CLOCK_IN),
      .RESET_N_IN (RESET_N_IN),
      .START_IN   (s.attr_start),
      .ADDR_IN    (attr_addr),
      .DATA_IN    (attr_data),
      .RSP_IN     (RCFG_RSP_IN),
      .REQ_OUT    (RCFG_REQ_OUT),
      .DONE_OUT   (attr_done),
      .MATCH_OUT  (attr_match)
   );

   // ==========================================================================
   // Outputs, all straight from flip-flops
   assign WB_DAT_OUT            = s.rdata;
   assign WB_ACK_OUT            = s.ack;
   assign TX_DATAPATH_RESET_OUT = s.rst_req;
   assign TX_FAIL_OUT           = s.fail;
   assign TX_FAIL_CODE_OUT      = s.code;
   assign TX_BUSY_OUT           = s.busy;

endmodule
`default_nettype wire

// [verification/tx_fail_checker.sv]
// Assertion checker for the transmit mode-change failure reporter
`timescale 1ns/1ns
`default_nettype none
module tx_fail_checker
   import tx_fail_pkg::*;
#(
   parameter int TX_RETRY_COUNTER_TOP_BIT = 3
)
(
   input wire logic                   CLOCK_IN,
   input wire logic                   RESET_N_IN,
   input wire tx_fail_pkg::rcfg_req_t RCFG_REQ_OUT,
   input wire logic                   TX_DATAPATH_RESET_OUT,
   input wire logic                   TX_FAIL_OUT,
   input wire logic [2:0]             TX_FAIL_CODE_OUT,
   input wire logic                   TX_BUSY_OUT
);
   import tx_fail_pkg::*;
   localparam int ATTEMPTS = 1 << TX_RETRY_COUNTER_TOP_BIT;
   // ==========
   // Attempt counters, cleared at each start
   int         wr_cnt;
   int         rst_cnt;
   logic [8:0] wr_addr;
   logic       busy_q;
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         wr_cnt <= 0;
         rst_cnt <= 0;
         wr_addr <= '0;
         busy_q <= 1'b0;
      end
      else
      begin
         busy_q <= TX_BUSY_OUT;
         if (RCFG_REQ_OUT.en && RCFG_REQ_OUT.we)
         begin
            wr_addr <= RCFG_REQ_OUT.addr;
            wr_cnt <= (RCFG_REQ_OUT.addr == wr_addr) ? wr_cnt + 1 : 1;
         end
         else if (TX_BUSY_OUT && !busy_q)
            wr_cnt <= 0;
         if (TX_DATAPATH_RESET_OUT)
            rst_cnt <= rst_cnt + 1;
         else if (TX_BUSY_OUT && !busy_q)
            rst_cnt <= 0;
      end
   end
   // ==========
   // Properties
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);
   code_legal_a: assert property (
      TX_FAIL_CODE_OUT >= 3'h1 && TX_FAIL_CODE_OUT <= 3'h4) else $error("reserved code");
   par_code_a: assert property (
      $rose(TX_FAIL_OUT) && rst_cnt == 0 && wr_addr == ADDR_PARALLEL_WIDTH |-> TX_FAIL_CODE_OUT == 3'h1)
      else $error("wrong parallel width code");
   int_code_a: assert property (
      $rose(TX_FAIL_OUT) && rst_cnt == 0 && wr_addr == ADDR_INTERNAL_WIDTH |-> TX_FAIL_CODE_OUT == 3'h2)
      else $error("wrong internal width code");
   div_code_a: assert property (
      $rose(TX_FAIL_OUT) && rst_cnt == 0 && wr_addr == ADDR_CLOCK_DIVIDER |-> TX_FAIL_CODE_OUT == 3'h3)
      else $error("wrong divider code");
   attr_retry_a: assert property (
      $rose(TX_FAIL_OUT) && rst_cnt == 0 |-> wr_cnt == ATTEMPTS) else $error("attribute attempts off");
   reset_retry_a: assert property (
      $rose(TX_FAIL_OUT) && rst_cnt != 0 |-> TX_FAIL_CODE_OUT == 3'h4 && rst_cnt == ATTEMPTS)
      else $error("reset attempts off");
   fail_idle_a: assert property (
      $rose(TX_FAIL_OUT) |-> !TX_BUSY_OUT) else $error("fail while busy");
   readback_addr_a: assert property (
      RCFG_REQ_OUT.en && !RCFG_REQ_OUT.we |-> RCFG_REQ_OUT.addr == wr_addr) else $error("readback address");
   reset_pulse_a: assert property (
      TX_DATAPATH_RESET_OUT |-> TX_BUSY_OUT ##1 !TX_DATAPATH_RESET_OUT) else $error("reset pulse");
endmodule
bind tx_mode_change_failure_report tx_fail_checker #(.TX_RETRY_COUNTER_TOP_BIT(TX_RETRY_COUNTER_TOP_BIT)) chk_i (
   .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .RCFG_REQ_OUT(RCFG_REQ_OUT),
   .TX_DATAPATH_RESET_OUT(TX_DATAPATH_RESET_OUT), .TX_FAIL_OUT(TX_FAIL_OUT),
   .TX_FAIL_CODE_OUT(TX_FAIL_CODE_OUT), .TX_BUSY_OUT(TX_BUSY_OUT));
`default_nettype wire

// [verification/rcfg_partner.sv]
// Behavioural reconfiguration port and transmit reset helper
`timescale 1ns/1ns
`default_nettype none
module rcfg_partner
   import tx_fail_pkg::*;
(
   input  wire logic                   CLOCK_IN,
   input  wire logic                   RESET_N_IN,
   input  wire tx_fail_pkg::rcfg_req_t REQ_IN,
   output var  tx_fail_pkg::rcfg_rsp_t RSP_OUT,
   input  wire logic                   RST_REQ_IN,
   output logic                        RST_DONE_OUT,
   input  wire logic [8:0]             BAD_ADDR_IN,
   input  wire logic                   NO_DONE_IN,
   input  wire logic [3:0]             LAT_IN
);
   import tx_fail_pkg::*;
   logic [15:0] mem [16];
   rcfg_req_t   held;
   int          wait_cnt;
   int          done_cnt;
   // ==========
   // One fixed clock serves port and helper
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
   begin
      if (!RESET_N_IN)
      begin
         wait_cnt <= -1;
         done_cnt <= -1;
         RSP_OUT <= '0;
         RST_DONE_OUT <= 1'b0;
         held <= '0;
      end
      else
      begin
         RSP_OUT.rdy <= 1'b0;
         // Idle data toggles so stale reads never look valid
         RSP_OUT.rdata <= ~RSP_OUT.rdata;
         if (REQ_IN.en)
         begin
            held <= REQ_IN;
            wait_cnt <= int'(LAT_IN);
         end
         else if (wait_cnt > 0)
            wait_cnt <= wait_cnt - 1;
         else if (wait_cnt == 0)
         begin
            wait_cnt <= -1;
            RSP_OUT.rdy <= 1'b1;
            if (held.we)
               mem[held.addr[3:0]] <= held.wdata;
            else
               RSP_OUT.rdata <= mem[held.addr[3:0]] ^ {15'h0000, held.addr == BAD_ADDR_IN};
         end
         if (RST_REQ_IN)
         begin
            RST_DONE_OUT <= 1'b0;
            done_cnt <= NO_DONE_IN ? -1 : 5;
         end
         else if (done_cnt > 0)
            done_cnt <= done_cnt - 1;
         else if (done_cnt == 0)
         begin
            done_cnt <= -1;
            RST_DONE_OUT <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench for the transmit mode-change failure reporter
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import tx_fail_pkg::*;
   localparam logic [31:0] SMASK = 32'h00000077;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        ack;
   rcfg_req_t   req;
   rcfg_rsp_t   rsp;
   logic        rst_req;
   logic        rst_done;
   logic        fail;
   logic [2:0]  code;
   logic        busy;
   logic [8:0]  bad = 9'h1FF;
   logic        no_done = 1'b0;
   logic [3:0]  lat = 4'h0;
   int          seed = 7968;
   int          err_total = 0;
   int          n_compared = 0;
   always #25 clk = ~clk;
   tx_mode_change_failure_report #(.TX_RETRY_COUNTER_TOP_BIT(1), .RESET_DONE_WAIT(20)) DUT (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
      .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
      .RCFG_REQ_OUT(req), .RCFG_RSP_IN(rsp), .TX_DATAPATH_RESET_OUT(rst_req),
      .TX_RESET_DONE_IN(rst_done), .TX_FAIL_OUT(fail), .TX_FAIL_CODE_OUT(code), .TX_BUSY_OUT(busy));
   rcfg_partner far (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .REQ_IN(req), .RSP_OUT(rsp), .RST_REQ_IN(rst_req),
      .RST_DONE_OUT(rst_done), .BAD_ADDR_IN(bad), .NO_DONE_IN(no_done), .LAT_IN(lat));
   // ==========
   // Expectations
   function automatic logic [2:0] exp_code(input int i);
      return (i == 0) ? FAIL_PARALLEL_WIDTH : (i == 1) ? FAIL_INTERNAL_WIDTH : FAIL_CLOCK_DIVIDER;
   endfunction
   function automatic logic [8:0] attr_addr(input int i);
      return (i == 0) ? ADDR_PARALLEL_WIDTH : (i == 1) ? ADDR_INTERNAL_WIDTH : ADDR_CLOCK_DIVIDER;
   endfunction
   function automatic logic [31:0] stat_bits(input logic dn, input logic fl, input logic [2:0] c);
      return ({31'h0, dn} << STAT_DONE_BIT) | ({31'h0, fl} << STAT_FAIL_BIT) | ({29'h0, c} << STAT_CODE_LSB);
   endfunction
   // ==========
   // Tasks
   task automatic conclude();
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 50);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      chk("ack", 32'h1, {31'h0, ack});
   endtask
   task automatic run(input logic [2:0] en, input logic [8:0] v, output logic [31:0] st);
      logic [31:0] q;
      int n;
      n = 0;
      bus(1'b1, REG_VALUES, {23'h0, v}, q);
      bus(1'b1, REG_CONTROL, {28'h0, en, 1'b1}, q);
      repeat (4) @(posedge clk);
      do
      begin
         bus(1'b0, REG_STATUS, 32'h0, st);
         n++;
      end
      while (st[STAT_BUSY_BIT] !== 1'b0 && n < 400);
      chk("busy port", 32'h0, {31'h0, busy});
   endtask
   // ==========
   // Stimulus
   initial
   begin
      repeat (20000) @(posedge clk);
      err_total++;
      conclude();
   end
   initial
   begin
      logic [31:0] q;
      logic [31:0] st;
      logic [8:0]  v;
      logic [2:0]  last_code;
      last_code = FAIL_PARALLEL_WIDTH;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, REG_STATUS, 32'h0, q);
      chk("status reset", {24'h0, 1'b0, FAIL_PARALLEL_WIDTH, 4'h0}, q);
      bus(1'b0, REG_VALUES, 32'h0, q);
      chk("values reset", 32'h0, q);
      bus(1'b1, 8'h0C, 32'hFFFFFFFF, q);
      bus(1'b0, 8'h0C, 32'h0, q);
      chk("unmapped", 32'h0, q);
      for (int i = 0; i < 6; i++)
      begin
         v = 9'($random(seed));
         lat <= 4'($random(seed));
         run(3'h7, v, st);
         chk("good status", stat_bits(1'b1, 1'b0, last_code), st & SMASK);
         chk("parallel attr", {28'h0, v[3:0]}, {16'h0, far.mem[4'hA]});
         chk("internal attr", {30'h0, v[5:4]}, {16'h0, far.mem[4'h5]});
         chk("divider attr", {29'h0, v[8:6]}, {16'h0, far.mem[4'hC]});
      end
      for (int i = 0; i < 3; i++)
      begin
         bad <= attr_addr(i);
         run(3'h7 & ~(3'h1 << i), 9'($random(seed)), st);
         chk("skipped attr", stat_bits(1'b1, 1'b0, last_code), st & SMASK);
         run(3'h7, 9'($random(seed)), st);
         chk("attr fail", stat_bits(1'b0, 1'b1, exp_code(i)), st & SMASK);
         chk("fail port", {28'h0, 1'b1, exp_code(i)}, {28'h0, fail, code});
         last_code = exp_code(i);
      end
      bad <= 9'h1FF;
      no_done <= 1'b1;
      run(3'($random(seed)), 9'($random(seed)), st);
      chk("reset fail", stat_bits(1'b0, 1'b1, FAIL_RESET_DONE), st & SMASK);
      last_code = FAIL_RESET_DONE;
      chk("reset port", {28'h0, 1'b1, FAIL_RESET_DONE}, {28'h0, fail, code});
      no_done <= 1'b0;
      run(3'h7, 9'($random(seed)), st);
      chk("recovered", stat_bits(1'b1, 1'b0, last_code), st & SMASK);
      conclude();
   end
endmodule
`default_nettype wire
